// ==== include/hcs_map.svh ====
`ifndef HCS_MAP_SVH
`define HCS_MAP_SVH

// Wishbone register byte offsets
`define HCS_REG_CTRL 8'h00
`define HCS_REG_STATUS 8'h04
`define HCS_REG_IDENT 8'h08
`define HCS_REG_DEVREL 8'h0c
`define HCS_REG_OPTS 8'h10
`define HCS_REG_EFFECT 8'h14
`define HCS_REG_TTINFO 8'h18

// Option field positions (OPTS and EFFECT)
`define HCS_OPT_LOCAL_POWER_DETECT 0
`define HCS_OPT_GANGED 1
`define HCS_OPT_HS_DIS 2
`define HCS_OPT_EOP_EN 3
`define HCS_OPT_COMPOUND 4
`define HCS_OPT_FIXED_LSB 8
`define HCS_OPT_SPDIS_LSB 12

// Control fields
`define HCS_CTRL_LOAD_DONE 0

// Built-in identity values (arbitrary, neutral)
`define HCS_DEF_VENDOR 16'h1234
`define HCS_DEF_PRODUCT 16'h5678
`define HCS_DEF_DEVREL 16'h0000

// Slave address for the download mode
`define HCS_SMB_ADDR 7'h2c

// Port and translator counts
`define HCS_PORTS 2
`define HCS_TT_BUFS 4

// Straps settle: two sync stages then one capture cycle
`define HCS_STRAP_SETTLE 2'd3

`endif

// ==== include/hcs_pkg.sv ====
package hcs_pkg;
	typedef enum logic [1:0] {
		HCS_SRC_RSVD = 2'b00,
		HCS_SRC_SMBUS = 2'b01,
		HCS_SRC_STRAP = 2'b10,
		HCS_SRC_EEPROM = 2'b11
	} hcs_src_e;

	typedef enum logic [1:0] {
		HCS_ST_SETTLE = 2'b00,
		HCS_ST_LOAD = 2'b01,
		HCS_ST_READY = 2'b10,
		HCS_ST_HALT = 2'b11
	} hcs_state_e;
endpackage

// ==== rtl/hcs_sync.sv ====
`timescale 1ns/1ps
module hcs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_r;

	// First stage is read by the second stage only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o <= '0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule

// ==== rtl/hcs_config_select.sv ====
// Contract
// R1: Sample method straps at reset release
// R2: Vendor id 16 bits, built-in default
// R3: Product id 16 bits, built-in default
// R4: Release number 16-bit BCD, built-in default
// R5: Power mode from load, else detect pin
// R6: Sensing ganged or none; strap follows power
// R7: High-speed disable forces full speed only
// R8: Early EOP allowed in full speed only
// R9: Compound setter also marks fixed ports
// R10: Strap fixed port implies compound device
// R11: Fixed port mask from load or straps
// R12: Self-powered disable mask keeps ports off
// R13: Ports disabled downward from port two
// R14: One translator per port, four buffers
// R15: Strap code selects SMBus, straps, EEPROM
// R16: SMBus slave address 0101100
// R17: Detect high means local power present
// R18: EEPROM read completes before attach
// R19: Strapless options default inactive
`timescale 1ns/1ps
`include "hcs_map.svh"
module hcs_config_select import hcs_pkg::*; #(
	parameter int PORTS = `HCS_PORTS,
	parameter int TT_BUFS = `HCS_TT_BUFS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic config_method_strap_hi_i,
	input wire logic config_method_strap_lo_i,
	input wire logic local_power_detect_i,
	input wire logic [1:0] fixed_device_straps_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic [1:0] config_source_o,
	output logic smbus_slave_en_o,
	output logic [6:0] smbus_slave_addr_o,
	output logic eeprom_load_en_o,
	output logic attach_en_o,
	output logic [15:0] vendor_id_o,
	output logic [15:0] product_id_o,
	output logic [15:0] device_release_o,
	output logic self_powered_o,
	output logic ganged_sense_o,
	output logic high_speed_en_o,
	output logic early_eop_en_o,
	output logic compound_o,
	output logic [1:0] fixed_ports_o,
	output logic [1:0] port_disabled_o,
	output logic [1:0] tt_count_o,
	output logic [2:0] tt_bufs_o
);
	logic strap_hi_s;
	logic strap_lo_s;
	logic power_s;
	logic [1:0] fixed_s;
	logic [1:0] settle_r;
	logic [1:0] settle_nxt;
	hcs_src_e src_r;
	hcs_state_e state_r;
	hcs_state_e state_nxt;
	logic [1:0] fixed_strap_r;
	logic [15:0] vendor_r;
	logic [15:0] product_r;
	logic [15:0] devrel_r;
	logic [15:0] opts_r;
	logic load_done_r;

	hcs_sync #(.WIDTH(5)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({config_method_strap_hi_i, config_method_strap_lo_i,
			local_power_detect_i, fixed_device_straps_i}),
		.q_o({strap_hi_s, strap_lo_s, power_s, fixed_s})
	);

	// Register decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr_go = bus_req & wb_we_i;
	wire sel_ctrl = hit(wb_adr_i, `HCS_REG_CTRL);
	wire sel_status = hit(wb_adr_i, `HCS_REG_STATUS);
	wire sel_ident = hit(wb_adr_i, `HCS_REG_IDENT);
	wire sel_devrel = hit(wb_adr_i, `HCS_REG_DEVREL);
	wire sel_opts = hit(wb_adr_i, `HCS_REG_OPTS);
	wire sel_effect = hit(wb_adr_i, `HCS_REG_EFFECT);
	wire sel_tt = hit(wb_adr_i, `HCS_REG_TTINFO);
	// Downloads accepted only while a load source is active
	wire loading = (state_r == HCS_ST_LOAD);
	wire wr_ident = wr_go & sel_ident & loading;
	wire wr_devrel = wr_go & sel_devrel & loading;
	wire wr_opts = wr_go & sel_opts & loading;
	wire wr_ctrl = wr_go & sel_ctrl & loading;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] be);
		merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction

	wire from_strap = (src_r == HCS_SRC_STRAP);
	wire use_dl = (src_r == HCS_SRC_SMBUS) | (src_r == HCS_SRC_EEPROM);

	// Settle counter lets the straps pass the synchroniser
	assign settle_nxt = (settle_r == `HCS_STRAP_SETTLE) ? settle_r :
		settle_r + 2'd1;
	wire settled = (settle_r == `HCS_STRAP_SETTLE);
	wire [1:0] strap_code = {strap_hi_s, strap_lo_s};

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			HCS_ST_SETTLE: begin
				if (settled) begin
					case (strap_code)
						2'b10: state_nxt = HCS_ST_READY;
						2'b01, 2'b11: state_nxt = HCS_ST_LOAD;
						default: state_nxt = HCS_ST_HALT;
					endcase
				end
			end
			HCS_ST_LOAD: begin
				if (load_done_r)
					state_nxt = HCS_ST_READY; // see R18
			end
			HCS_ST_READY: state_nxt = HCS_ST_READY;
			HCS_ST_HALT: state_nxt = HCS_ST_HALT;
			default: state_nxt = HCS_ST_HALT;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_r <= 2'd0;
			state_r <= HCS_ST_SETTLE;
		end else begin
			settle_r <= settle_nxt;
			state_r <= state_nxt;
		end
	end

	// Method straps caught once, when the settle count is reached after reset release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_r <= HCS_SRC_RSVD;
			fixed_strap_r <= 2'b00;
		end else if (state_r == HCS_ST_SETTLE && settled) begin
			src_r <= hcs_src_e'(strap_code); // see R1 see R15
			fixed_strap_r <= fixed_s;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vendor_r <= `HCS_DEF_VENDOR;
			product_r <= `HCS_DEF_PRODUCT;
			devrel_r <= `HCS_DEF_DEVREL;
			opts_r <= 16'h0000;
			load_done_r <= 1'b0;
		end else begin
			if (wr_ident) begin
				vendor_r <= merge16(vendor_r, wb_dat_i[15:0],
					wb_sel_i[1:0]); // see R2
				product_r <= merge16(product_r, wb_dat_i[31:16],
					wb_sel_i[3:2]); // see R3
			end
			if (wr_devrel)
				devrel_r <= merge16(devrel_r, wb_dat_i[15:0],
					wb_sel_i[1:0]); // see R4
			if (wr_opts)
				opts_r <= merge16(opts_r, wb_dat_i[15:0], wb_sel_i[1:0]);
			if (wr_ctrl && wb_sel_i[0] && wb_dat_i[`HCS_CTRL_LOAD_DONE])
				load_done_r <= 1'b1;
		end
	end

	// Effective options
	wire dl_self = opts_r[`HCS_OPT_LOCAL_POWER_DETECT];
	wire dl_gang = opts_r[`HCS_OPT_GANGED];
	wire [1:0] dl_fixed = opts_r[`HCS_OPT_FIXED_LSB +: 2];
	wire [1:0] dl_spdis = opts_r[`HCS_OPT_SPDIS_LSB +: 2];
	// Detect high means local power present
	wire eff_self = from_strap ? power_s : dl_self; // see R5 see R17
	wire eff_gang = from_strap ? eff_self :
		dl_gang; // see R6
	wire eff_hsdis = use_dl & opts_r[`HCS_OPT_HS_DIS]; // see R19
	wire eff_eop = use_dl & opts_r[`HCS_OPT_EOP_EN];
	wire [1:0] eff_fixed = from_strap ? fixed_strap_r : dl_fixed; // see R11
	// Compound flag set by a loader is trusted to match its mask
	wire eff_comp = from_strap ? |fixed_strap_r :
		opts_r[`HCS_OPT_COMPOUND]; // see R10 see R9
	wire [1:0] eff_spdis = use_dl ? dl_spdis : 2'b00;
	wire ready = (state_r == HCS_ST_READY);

	wire [15:0] eff_word = {2'b00, eff_spdis, 2'b00, eff_fixed, 3'b000,
		eff_comp, eff_eop, eff_hsdis, eff_gang, eff_self};

	wire [15:0] out_vendor = from_strap ? `HCS_DEF_VENDOR : vendor_r;
	wire [15:0] out_product = from_strap ? `HCS_DEF_PRODUCT : product_r;
	wire [15:0] out_devrel = from_strap ? `HCS_DEF_DEVREL : devrel_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			config_source_o <= 2'b00;
			smbus_slave_en_o <= 1'b0;
			smbus_slave_addr_o <= `HCS_SMB_ADDR;
			eeprom_load_en_o <= 1'b0;
			attach_en_o <= 1'b0;
			vendor_id_o <= `HCS_DEF_VENDOR;
			product_id_o <= `HCS_DEF_PRODUCT;
			device_release_o <= `HCS_DEF_DEVREL;
			self_powered_o <= 1'b0;
			ganged_sense_o <= 1'b0;
			high_speed_en_o <= 1'b0;
			early_eop_en_o <= 1'b0;
			compound_o <= 1'b0;
			fixed_ports_o <= 2'b00;
			port_disabled_o <= 2'b00;
			tt_count_o <= 2'b00;
			tt_bufs_o <= 3'b000;
		end else begin
			config_source_o <= src_r;
			smbus_slave_en_o <= loading && src_r == HCS_SRC_SMBUS; // see R16
			smbus_slave_addr_o <= `HCS_SMB_ADDR; // see R16
			eeprom_load_en_o <= loading && src_r == HCS_SRC_EEPROM;
			attach_en_o <= ready; // see R18
			vendor_id_o <= out_vendor;
			product_id_o <= out_product;
			device_release_o <= out_devrel;
			self_powered_o <= eff_self;
			ganged_sense_o <= eff_gang;
			high_speed_en_o <= ~eff_hsdis; // see R7
			early_eop_en_o <= eff_eop & eff_hsdis; // see R8
			compound_o <= eff_comp;
			fixed_ports_o <= eff_fixed;
			// Disable mask applies only while self-powered
			port_disabled_o <= eff_self ? eff_spdis : 2'b00; // see R12 see R13
			tt_count_o <= 2'(PORTS); // see R14
			tt_bufs_o <= 3'(TT_BUFS); // see R14
		end
	end

	// Read mux
	logic [31:0] rd_data;
	assign rd_data = sel_ctrl ? {31'h0, load_done_r} :
		sel_status ? {26'h0, state_r, 2'b00, src_r} :
		sel_ident ? {out_product, out_vendor} :
		sel_devrel ? {16'h0, out_devrel} :
		sel_opts ? {16'h0, opts_r} :
		sel_effect ? {16'h0, eff_word} :
		sel_tt ? {24'h0, 3'(TT_BUFS), 3'b000, 2'(PORTS)} :
		32'h0000_0000;

	// One-wait answer; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= rd_data;
		end
	end

	strap_code_a: assert property ( // see R1
		@(posedge clk_i) disable iff (rst_i)
		(state_r == HCS_ST_SETTLE && settled) |=> src_r == $past(strap_code))
		else $error("method straps not captured");
	default_ids_a: assert property ( // see R2
		@(posedge clk_i) disable iff (rst_i) (from_strap && ready) |=>
		vendor_id_o == `HCS_DEF_VENDOR && product_id_o == `HCS_DEF_PRODUCT)
		else $error("defaults wrong");
	devrel_def_a: assert property ( // see R4
		@(posedge clk_i) disable iff (rst_i)
		from_strap |=> device_release_o == `HCS_DEF_DEVREL)
		else $error("release default wrong");
	strap_power_a: assert property ( // see R6
		@(posedge clk_i) disable iff (rst_i) from_strap |=>
		self_powered_o == $past(power_s) && ganged_sense_o == $past(power_s))
		else $error("power wrong");
	hs_only_a: assert property ( // see R8
		@(posedge clk_i) disable iff (rst_i)
		high_speed_en_o |-> !early_eop_en_o)
		else $error("early eop in high speed");
	strap_comp_a: assert property ( // see R10
		@(posedge clk_i) disable iff (rst_i)
		from_strap |=> compound_o == |fixed_strap_r)
		else $error("compound not derived");
	port_dis_a: assert property ( // see R12
		@(posedge clk_i) disable iff (rst_i)
		!self_powered_o |-> port_disabled_o == 2'b00)
		else $error("ports off while bus powered");
	attach_gate_a: assert property ( // see R18
		@(posedge clk_i) disable iff (rst_i)
		(loading && !load_done_r) |=> !attach_en_o)
		else $error("attached before load");
	strap_inact_a: assert property ( // see R19
		@(posedge clk_i) disable iff (rst_i)
		from_strap |=> high_speed_en_o && port_disabled_o == 2'b00)
		else $error("strapless option active");
	bus_ack_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		bus_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing wrong");
	dl_power_a: assert property ( // see R5
		@(posedge clk_i) disable iff (rst_i)
		use_dl |=> self_powered_o == $past(dl_self))
		else $error("loaded power mode not applied");
	dl_gang_a: assert property ( // see R6
		@(posedge clk_i) disable iff (rst_i)
		use_dl |=> ganged_sense_o == $past(dl_gang))
		else $error("loaded sensing not applied");
	hs_off_a: assert property ( // see R7
		@(posedge clk_i) disable iff (rst_i)
		(use_dl && opts_r[`HCS_OPT_HS_DIS]) |=> !high_speed_en_o)
		else $error("high speed offered while disabled");
	dl_fixed_a: assert property ( // see R11
		@(posedge clk_i) disable iff (rst_i)
		use_dl |=> fixed_ports_o == $past(dl_fixed))
		else $error("loaded fixed mask not applied");
	strap_fixed_a: assert property ( // see R11
		@(posedge clk_i) disable iff (rst_i)
		from_strap |=> fixed_ports_o == fixed_strap_r)
		else $error("strapped fixed mask not applied");
	spdis_on_a: assert property ( // see R12
		@(posedge clk_i) disable iff (rst_i)
		(use_dl && dl_self) |=> port_disabled_o == $past(dl_spdis))
		else $error("disable mask not applied");
	halt_quiet_a: assert property ( // see R15
		@(posedge clk_i) disable iff (rst_i)
		(state_r == HCS_ST_HALT) |=>
		!attach_en_o && !smbus_slave_en_o && !eeprom_load_en_o)
		else $error("reserved code left active");
	smb_addr_a: assert property ( // see R16
		@(posedge clk_i) disable iff (rst_i)
		smbus_slave_addr_o == `HCS_SMB_ADDR)
		else $error("slave address wrong");
	tt_info_a: assert property ( // see R14
		@(posedge clk_i) disable iff (rst_i)
		ready |=> tt_count_o == 2'(PORTS) && tt_bufs_o == 3'(TT_BUFS))
		else $error("translator counts wrong");
	src_out_a: assert property ( // see R1
		@(posedge clk_i) disable iff (rst_i)
		ready |=> config_source_o == src_r)
		else $error("source code not shown");
	ee_attach_a: assert property ( // see R18
		@(posedge clk_i) disable iff (rst_i)
		(src_r == HCS_SRC_EEPROM && !ready) |=> !attach_en_o)
		else $error("attached before eeprom read");
endmodule

// ==== verification/hcs_strap_model.sv ====
`timescale 1ns/1ps
module hcs_strap_model (
	input wire logic [1:0] method_i,
	input wire logic pwr_i,
	input wire logic [1:0] fixed_i,
	output logic strap_hi_o,
	output logic strap_lo_o,
	output logic power_o,
	output logic [1:0] fixed_o
);
	// Board straps are resistors, so they hold static levels
	assign strap_hi_o = method_i[1];
	assign strap_lo_o = method_i[0];
	assign power_o = pwr_i;
	assign fixed_o = fixed_i;
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`include "hcs_map.svh"
module tb import hcs_pkg::*;;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] method = 2'b10;
	logic pwr = 1'b0;
	logic [1:0] fixed = 2'b00;
	logic s_hi, s_lo, power, p, sm_en, ee_en, att, self_p, gang;
	logic hs_en, eop, cmpd;
	logic [1:0] fx, f, src, pdis, ttc;
	logic [2:0] ttb;
	logic [6:0] addr;
	logic [15:0] vid, pid, rel;
	logic [7:0] adr = 8'h00;
	logic [31:0] dw = 32'h0, dr, q;
	logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
	logic [3:0] sel = 4'hf;
	logic [1:0] fixed_pins;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;

	always #2 clk_i = ~clk_i;

	hcs_strap_model straps (.method_i(method), .pwr_i(pwr), .fixed_i(fixed),
		.strap_hi_o(s_hi), .strap_lo_o(s_lo), .power_o(power),
		.fixed_o(fixed_pins));

	hcs_config_select DUT (.clk_i(clk_i), .rst_i(rst_i),
		.config_method_strap_hi_i(s_hi), .config_method_strap_lo_i(s_lo),
		.local_power_detect_i(power), .fixed_device_straps_i(fixed_pins),
		.wb_adr_i(adr), .wb_dat_i(dw), .wb_dat_o(dr), .wb_we_i(we),
		.wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
		.config_source_o(src), .smbus_slave_en_o(sm_en),
		.smbus_slave_addr_o(addr), .eeprom_load_en_o(ee_en),
		.attach_en_o(att), .vendor_id_o(vid), .product_id_o(pid),
		.device_release_o(rel), .self_powered_o(self_p),
		.ganged_sense_o(gang), .high_speed_en_o(hs_en),
		.early_eop_en_o(eop), .compound_o(cmpd), .fixed_ports_o(fx),
		.port_disabled_o(pdis), .tt_count_o(ttc), .tt_bufs_o(ttb));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task final_report;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			final_report;
		end
	end

	task do_reset(input logic [1:0] m, input logic pw, input logic [1:0] fp);
		rst_i <= 1'b1;
		method <= m;
		pwr <= pw;
		fixed <= fp;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask

	// Ack and read data are taken at the edge where ack is seen high
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		adr <= a;
		dw <= d;
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	initial begin
		for (int i = 0; i < 4; i++) begin
			f = i[1:0];
			p = i[1];
			do_reset(2'b10, p, f);
			check(src, HCS_SRC_STRAP);
			check(att, 1'b1);
			check({pid, vid}, {`HCS_DEF_PRODUCT, `HCS_DEF_VENDOR});
			check(rel, `HCS_DEF_DEVREL);
			check(self_p, p);
			check(gang, p);
			check(cmpd, |f);
			check(fx, f);
			check({hs_en, eop, pdis}, 4'b1000);
		end
		do_reset(2'b00, 1'b1, 2'b00);
		check(att, 1'b0);
		wb(1'b0, `HCS_REG_STATUS, 32'h0);
		check(q[5:4], HCS_ST_HALT);
		do_reset(2'b01, 1'b0, 2'b00);
		check({src, sm_en, ee_en, att}, {HCS_SRC_SMBUS, 3'b100});
		check(addr, 7'h2c);
		// Bus powered with high speed left on: disable mask and early EOP must stay off
		wb(1'b1, `HCS_REG_OPTS, 32'h2008);
		wb(1'b1, `HCS_REG_CTRL, 32'h1);
		repeat (3) @(posedge clk_i);
		check({att, hs_en, eop, pdis}, 5'b11000);
		do_reset(2'b11, 1'b0, 2'b00);
		check({src, ee_en, att}, {HCS_SRC_EEPROM, 2'b10});
		wb(1'b1, `HCS_REG_IDENT, 32'h7777_def0);
		// Upper lanes only: vendor half must keep its value
		sel <= 4'hc;
		wb(1'b1, `HCS_REG_IDENT, 32'h9abc_5555);
		sel <= 4'hf;
		wb(1'b1, `HCS_REG_DEVREL, 32'h0123);
		wb(1'b1, `HCS_REG_OPTS, 32'h221f);
		wb(1'b0, `HCS_REG_OPTS, 32'h0);
		check(q, 32'h221f);
		check(att, 1'b0);
		wb(1'b1, `HCS_REG_CTRL, 32'h1);
		repeat (3) @(posedge clk_i);
		check({ee_en, att}, 2'b01);
		check({pid, vid, rel}, 48'h9abc_def0_0123);
		check({self_p, gang, cmpd, fx}, 5'b11110);
		check(hs_en, 1'b0);
		check(eop, 1'b1);
		check(pdis, 2'b10);
		wb(1'b1, `HCS_REG_IDENT, 32'h1111_2222);
		repeat (2) @(posedge clk_i);
		check(vid, 16'hdef0);
		wb(1'b0, `HCS_REG_TTINFO, 32'h0);
		check(q, 32'h82);
		check({ttc, ttb}, 5'b10100);
		wb(1'b0, 8'h40, 32'h0);
		check(q, 32'h0);
		final_report;
	end
endmodule
